// ==== shared/acc_regs.vh ====
`ifndef ACC_REGS_VH
`define ACC_REGS_VH
// correction word layout and special values
`define ACC_WORD_W 24
`define ACC_GAIN_UNITY 24'h40_0000
`define ACC_OFC_RESET 24'h00_0000
`define ACC_CODE_MAX 24'h7F_FFFF
`define ACC_CODE_MIN 24'h80_0000
// gain setting field width
`define ACC_GAIN_SEL_W 3
// calibration averaging
`define ACC_CAL_CONV 16
`define ACC_CAL_SHIFT 4
// timing counts in their own units
`define ACC_CAL_SYS_CLKS 50
`define ACC_MOD_SETTLE 32
`define ACC_POR_LOG2 16
// calibration kinds
`define ACC_CAL_NONE 2'h0
`define ACC_CAL_SGAIN 2'h1
`define ACC_CAL_SOFS 2'h2
`define ACC_CAL_IOFS 2'h3
`endif

// ==== design/acc_scaler.v ====
`timescale 1ns/1ps
`include "acc_regs.vh"
// scales a filter word by offset and gain, with saturation
module acc_scaler (
    input wire clk_i,
    input wire reset_n_i,
    input wire signed [23:0] raw_i,
    input wire signed [23:0] ofs_i,
    input wire [23:0] gain_i,
    output reg [23:0] code_o
);
    ////////////////////////////////////////////////////////////////////
    // difference kept at 25 bits so offset subtraction never wraps
    wire signed [24:0] diff;
    wire signed [49:0] prod;
    wire signed [49:0] scaled;
    assign diff = {raw_i[23], raw_i} - {ofs_i[23], ofs_i};
    assign prod = diff * $signed({1'b0, gain_i});
    assign scaled = prod >>> 22; // divide by unity code
    ////////////////////////////////////////////////////////////////////
    // clip to the 24-bit range by sign of the overflow
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            code_o <= 24'h00_0000;
        end else if (scaled > $signed({26'h0, `ACC_CODE_MAX})) begin
            code_o <= `ACC_CODE_MAX;
        end else if (scaled < -$signed({26'h0, `ACC_CODE_MIN})) begin
            code_o <= `ACC_CODE_MIN;
        end else begin
            code_o <= scaled[23:0];
        end
    end
endmodule

// ==== design/acc_trim_rom.v ====
`timescale 1ns/1ps
`include "acc_regs.vh"
// factory trimmed gain word per amplifier gain setting
module acc_trim_rom #(
    parameter [23:0] TRIM0 = 24'h40_0000,
    parameter [23:0] TRIM_STEP = 24'h00_0000
) (
    input wire clk_i,
    input wire [2:0] sel_i,
    output reg [23:0] trim_o
);
    ////////////////////////////////////////////////////////////////////
    // registered read; default trims are plain unity values
    always @(posedge clk_i) begin
        trim_o <= TRIM0 + TRIM_STEP * {21'h0, sel_i};
    end
endmodule

// ==== design/acc_control.v ====
`timescale 1ns/1ps
`include "acc_regs.vh"
// Functional notes
// - output is (input minus offset) times gain/400000h
// - result clipped to 24 bits
// - offset word signed 24 bits, zero means none
// - gain word unsigned, unity at 400000h
// - gain setting change reloads trimmed gain word
// - host writes or calibration update correction words
// - gain calibration stores new gain word
// - offset calibrations store new offset word
// - calibration command aborts conversion immediately
// - internal offset cal shorts inputs internally
// - done flag low after calibration, first result valid
// - sleep request during calibration waits for completion
// - calibration averages sixteen conversions
// - calibration adds 50 system, 32 modulator clocks
// - power-up holds logic reset 2^16 clocks
// - sleep by command or start pin; reference follows bits
// - start pulse gives one conversion then shutdown
// - start rise holds filter reset 32 modulator clocks
// - start held high converts continuously
// - temperature monitor forces unity gain, keeps stored bits
// - any monitor disconnects external inputs
module acc_control #(
    parameter POR_CLKS = 65536,
    parameter CONV_CLKS = 5000,
    parameter [23:0] FULL_SCALE = 24'h7F_FFFF
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire start_pin_i,
    input wire mod_clk_i,
    input wire filt_valid_i,
    input wire [23:0] filt_data_i,
    input wire sleep_cmd_i,
    input wire wakeup_cmd_i,
    input wire system_gain_cal_cmd_i,
    input wire system_offset_cal_cmd_i,
    input wire internal_offset_cal_cmd_i,
    input wire ofs_wr_i,
    input wire [23:0] ofs_wdata_i,
    input wire gain_wr_i,
    input wire [23:0] gain_wdata_i,
    input wire [2:0] amplifier_gain_setting_i,
    input wire [1:0] reference_control_bits_i,
    input wire [1:0] monitor_sel_i,
    output wire [23:0] offset_correction_word_o,
    output wire [23:0] gain_correction_word_o,
    output wire [23:0] result_o,
    output reg conversion_done_flag_o,
    output wire filter_reset_o,
    output wire inputs_disconnect_o,
    output wire internal_short_o,
    output wire [2:0] eff_gain_o,
    output wire ref_on_o,
    output wire por_busy_o,
    output wire cal_busy_o,
    output wire asleep_o
);
    ////////////////////////////////////////////////////////////////////
    // state encodings
    // calibration states adjacent, one range test finds them
    localparam [2:0] ST_POR = 3'h0;
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SETTLE = 3'h2;
    localparam [2:0] ST_CONV = 3'h3;
    localparam [2:0] ST_CAL_SYS = 3'h4;
    localparam [2:0] ST_CAL_MOD = 3'h5;
    localparam [2:0] ST_CAL_AVG = 3'h6;
    localparam [2:0] ST_SLEEP = 3'h7;
    // monitor code of the temperature diodes
    localparam [1:0] MON_TEMP = 2'h3;

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for start pin and modulator clock
    // chains reset low, the pins' idle level, so no false edge
    // modulator edges arrive late but each is counted once
    reg start_s1_r, start_s2_r, start_d_r;
    reg mod_s1_r, mod_s2_r, mod_d_r;
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            start_s1_r <= 1'b0;
            start_s2_r <= 1'b0;
            start_d_r <= 1'b0;
            mod_s1_r <= 1'b0;
            mod_s2_r <= 1'b0;
            mod_d_r <= 1'b0;
        end else begin
            start_s1_r <= start_pin_i;
            start_s2_r <= start_s1_r;
            start_d_r <= start_s2_r;
            mod_s1_r <= mod_clk_i;
            mod_s2_r <= mod_s1_r;
            mod_d_r <= mod_s2_r;
        end
    end
    // edge detectors read only the second and third flops
    wire start_rise = start_s2_r & ~start_d_r;
    wire mod_tick = mod_s2_r & ~mod_d_r; // one modulator edge
    wire cal_cmd = system_gain_cal_cmd_i | system_offset_cal_cmd_i | internal_offset_cal_cmd_i;

    ////////////////////////////////////////////////////////////////////
    // state, counters and calibration bookkeeping
    reg [2:0] state_r, state_nxt;
    // wide enough for the power-up hold, the longest count
    reg [16:0] cnt_r, cnt_nxt;
    reg [4:0] nconv_r, nconv_nxt;
    reg [1:0] cal_kind_r, cal_kind_nxt;
    reg sleep_pend_r, sleep_pend_nxt;
    // sixteen signed words need four guard bits
    reg signed [27:0] acc_r, acc_nxt;
    reg [23:0] ofs_r, ofs_nxt;
    reg [23:0] gain_r, gain_nxt;
    reg [2:0] gsel_d_r;
    reg trim_load_r;
    reg done_pulse; // completion event this cycle
    wire [23:0] trim_word;
    wire signed [27:0] avg_sum = acc_r + {{4{filt_data_i[23]}}, filt_data_i};
    wire [23:0] avg_val = avg_sum[27:4];

    // trimmed gain lookup, one cycle latency
    // only the stored word is replaced, never the setting bits
    acc_trim_rom u_trim (
        .clk_i(clk_i),
        .sel_i(amplifier_gain_setting_i),
        .trim_o(trim_word)
    );

    // a gain change is seen here, the trim word lands next cycle
    // load flag resets high so the trim in force at release is used
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            gsel_d_r <= 3'h0;
            trim_load_r <= 1'b1;
        end else begin
            gsel_d_r <= amplifier_gain_setting_i;
            trim_load_r <= (gsel_d_r != amplifier_gain_setting_i);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    // writes, then sequencing, then overrides, rising in priority
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        nconv_nxt = nconv_r;
        cal_kind_nxt = cal_kind_r;
        sleep_pend_nxt = sleep_pend_r;
        acc_nxt = acc_r;
        ofs_nxt = ofs_r;
        gain_nxt = gain_r;
        done_pulse = 1'b0;
        // host writes, overridden by calibration in the same cycle
        if (ofs_wr_i) begin
            ofs_nxt = ofs_wdata_i;
        end
        if (trim_load_r) begin
            gain_nxt = trim_word;
        end else if (gain_wr_i) begin
            gain_nxt = gain_wdata_i;
        end
        // per-state sequencing; aborts and deferrals follow the case
        case (state_r)
        ST_POR: begin
            // hold the sequence until the power-on count expires; host writes still land
            cnt_nxt = cnt_r + 17'h1;
            if (cnt_r == POR_CLKS[16:0] - 17'h1) begin
                state_nxt = ST_IDLE;
                cnt_nxt = 17'h0;
            end
        end
        ST_IDLE, ST_SLEEP: begin
            // rest: wait for a command, a start edge or a wake-up
            if (cal_cmd) begin
                state_nxt = ST_CAL_SYS;
            end else if (start_rise || (wakeup_cmd_i && start_s2_r)) begin
                state_nxt = ST_SETTLE;
                cnt_nxt = 17'h0;
            end
        end
        ST_SETTLE: begin
            // filter held in reset for modulator edges
            if (mod_tick) begin
                cnt_nxt = cnt_r + 17'h1;
            end
            if (mod_tick && cnt_r == `ACC_MOD_SETTLE - 1) begin
                state_nxt = ST_CONV;
            end
        end
        ST_CONV: begin
            // each filter word is a result; low start ends the run
            if (filt_valid_i) begin
                done_pulse = 1'b1;
                if (!start_s2_r || sleep_cmd_i) begin
                    state_nxt = ST_SLEEP;
                end
                // stay converting while start stays high
            end else if (sleep_cmd_i) begin
                state_nxt = ST_SLEEP;
            end
        end
        ST_CAL_SYS: begin
            // fixed part of the calibration, in system clocks
            cnt_nxt = cnt_r + 17'h1;
            if (cnt_r == `ACC_CAL_SYS_CLKS - 1) begin
                state_nxt = ST_CAL_MOD;
                cnt_nxt = 17'h0;
            end
        end
        ST_CAL_MOD: begin
            // modulator settle, then the averager starts from zero
            if (mod_tick) begin
                cnt_nxt = cnt_r + 17'h1;
            end
            if (mod_tick && cnt_r == `ACC_MOD_SETTLE - 1) begin
                state_nxt = ST_CAL_AVG;
                nconv_nxt = 5'h0;
                acc_nxt = 28'sh0;
            end
        end
        ST_CAL_AVG: begin
            // sixteen back-to-back results are summed
            if (filt_valid_i) begin
                acc_nxt = avg_sum;
                nconv_nxt = nconv_r + 5'h1;
                if (nconv_r == `ACC_CAL_CONV - 1) begin
                    if (cal_kind_r == `ACC_CAL_SGAIN) begin
                        gain_nxt = cal_gain(avg_val, gain_r);
                    end else begin
                        ofs_nxt = avg_val;
                    end
                    done_pulse = 1'b1;
                    state_nxt = sleep_pend_r ? ST_SLEEP : ST_CONV;
                    sleep_pend_nxt = 1'b0;
                end
            end
        end
        // all codes are used; this only guards against upsets
        default: state_nxt = ST_IDLE;
        endcase
        if (state_r >= ST_CAL_SYS && state_r <= ST_CAL_AVG && (sleep_cmd_i || !start_s2_r)) begin
            sleep_pend_nxt = 1'b1;
        end
        if (state_r == ST_CONV && sleep_cmd_i && !filt_valid_i) begin
            state_nxt = ST_SLEEP;
        end
        // calibration aborts whatever is running except the power-up hold
        // and drops a sleep deferred by an earlier calibration
        if (cal_cmd && state_r != ST_POR) begin
            state_nxt = ST_CAL_SYS;
            cnt_nxt = 17'h0;
            sleep_pend_nxt = 1'b0;
            cal_kind_nxt = system_gain_cal_cmd_i ? `ACC_CAL_SGAIN :
                system_offset_cal_cmd_i ? `ACC_CAL_SOFS : `ACC_CAL_IOFS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // gain calibration: scale so averaged full-scale maps to target
    function [23:0] cal_gain;
        input [23:0] avg;
        input [23:0] cur;
        reg [47:0] num;
        reg [47:0] quo;
        begin
            num = {24'h0, FULL_SCALE} * {24'h0, cur};
            quo = 48'h0;
            if (avg == 24'h0 || avg[23]) begin
                // no usable full-scale reading, keep the old word
                cal_gain = cur;
            end else begin
                quo = num / {24'h0, avg};
                // limitation: a tiny reading saturates at the top gain
                cal_gain = (quo > 48'h0000_00FF_FFFF) ? 24'hFF_FFFF : quo[23:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // registers
    // one process, so every state bit shares the same reset
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_r <= ST_POR;
            cnt_r <= 17'h0;
            nconv_r <= 5'h0;
            cal_kind_r <= `ACC_CAL_NONE;
            sleep_pend_r <= 1'b0;
            acc_r <= 28'sh0;
            ofs_r <= `ACC_OFC_RESET;
            gain_r <= `ACC_GAIN_UNITY;
            conversion_done_flag_o <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            nconv_r <= nconv_nxt;
            cal_kind_r <= cal_kind_nxt;
            sleep_pend_r <= sleep_pend_nxt;
            acc_r <= acc_nxt;
            ofs_r <= ofs_nxt;
            gain_r <= gain_nxt;
            // low marks new data, high again when settling or a calibration starts
            if (done_pulse) begin
                conversion_done_flag_o <= 1'b0;
            end else if (state_nxt == ST_SETTLE || state_nxt == ST_CAL_SYS) begin
                conversion_done_flag_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result path and status outputs
    // levels decoded from state, no extra register delay
    acc_scaler u_scaler (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .raw_i(filt_data_i),
        .ofs_i(ofs_r),
        .gain_i(gain_r),
        .code_o(result_o)
    );
    assign offset_correction_word_o = ofs_r;
    assign gain_correction_word_o = gain_r;
    assign filter_reset_o = state_r == ST_POR || state_r == ST_SETTLE ||
        state_r == ST_CAL_SYS || state_r == ST_CAL_MOD;
    assign internal_short_o = cal_kind_r == `ACC_CAL_IOFS && state_r >= ST_CAL_SYS &&
        state_r <= ST_CAL_AVG;
    assign inputs_disconnect_o = internal_short_o || monitor_sel_i != 2'h0;
    // temperature monitor forces unity on the amplifier only
    assign eff_gain_o = monitor_sel_i == MON_TEMP ? 3'h0 : amplifier_gain_setting_i;
    assign asleep_o = state_r == ST_SLEEP;
    // awake, any set control bit keeps the reference on
    assign ref_on_o = asleep_o ? reference_control_bits_i[0] :
        (reference_control_bits_i != 2'h0);
    assign por_busy_o = state_r == ST_POR;
    assign cal_busy_o = state_r >= ST_CAL_SYS && state_r <= ST_CAL_AVG;
endmodule

// ==== testbench/acc_control_properties.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// port-level checker for the control block
module acc_control_chk #(
    parameter POR_CLKS = 65536
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire filt_valid_i,
    input wire [23:0] filt_data_i,
    input wire system_gain_cal_cmd_i,
    input wire system_offset_cal_cmd_i,
    input wire sleep_cmd_i,
    input wire internal_offset_cal_cmd_i,
    input wire ofs_wr_i,
    input wire [23:0] ofs_wdata_i,
    input wire [2:0] amplifier_gain_setting_i,
    input wire [1:0] monitor_sel_i,
    input wire [23:0] offset_correction_word_o,
    input wire [23:0] gain_correction_word_o,
    input wire [23:0] result_o,
    input wire conversion_done_flag_o,
    input wire inputs_disconnect_o,
    input wire internal_short_o,
    input wire [2:0] eff_gain_o,
    input wire por_busy_o,
    input wire cal_busy_o,
    input wire asleep_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    int por_cnt_r; // length of the running power-up hold
    // count hold cycles; cleared when it drops so the drop sees the total
    always @(posedge clk_i) begin
        if (!reset_n_i || !por_busy_o) begin
            por_cnt_r <= 0;
        end else begin
            por_cnt_r <= por_cnt_r + 1;
        end
    end
    logic slp_req_r; // sleep asked for during the running calibration
    always @(posedge clk_i) begin
        if (!reset_n_i || !cal_busy_o || system_gain_cal_cmd_i || system_offset_cal_cmd_i
            || internal_offset_cal_cmd_i) begin
            slp_req_r <= 1'b0;
        end else if (sleep_cmd_i) begin
            slp_req_r <= 1'b1;
        end
    end
    // release edge is ambiguous by one cycle, hence the two-value window
    por_hold_a: assert property ($fell(por_busy_o) |->
        por_cnt_r >= POR_CLKS && por_cnt_r <= POR_CLKS + 1) else $error("hold length wrong");
    unity_pass_a: assert property (filt_valid_i && gain_correction_word_o == 24'h40_0000
        && offset_correction_word_o == 24'h00_0000 |=> result_o == $past(filt_data_i))
        else $error("unity scaling altered code");
    clip_high_a: assert property (filt_valid_i && gain_correction_word_o == 24'h80_0000
        && offset_correction_word_o == 24'h00_0000 && filt_data_i[23:22] == 2'b01
        |=> result_o == 24'h7F_FFFF) else $error("positive overflow not clipped");
    done_low_a: assert property (filt_valid_i && !cal_busy_o && !asleep_o && !por_busy_o
        |=> !conversion_done_flag_o) else $error("done flag not low after result");
    cal_start_a: assert property (system_gain_cal_cmd_i && !por_busy_o
        |=> cal_busy_o && conversion_done_flag_o) else $error("calibration did not start");
    cal_done_a: assert property ($fell(cal_busy_o) |-> ##[0:1] !conversion_done_flag_o)
        else $error("done flag not low after calibration");
    short_in_a: assert property (internal_offset_cal_cmd_i && !por_busy_o
        |=> internal_short_o && inputs_disconnect_o) else $error("inputs not shorted");
    sleep_defer_a: assert property (cal_busy_o && slp_req_r ##1 !cal_busy_o |-> asleep_o)
        else $error("deferred sleep not taken");
    temp_gain_a: assert property (eff_gain_o ==
        (monitor_sel_i == 2'h3 ? 3'h0 : amplifier_gain_setting_i)) else $error("gain override wrong");
    mon_disc_a: assert property (monitor_sel_i != 2'h0 |-> inputs_disconnect_o)
        else $error("monitor left inputs connected");
    ofs_write_a: assert property (ofs_wr_i && !por_busy_o && !cal_busy_o
        |=> offset_correction_word_o == $past(ofs_wdata_i)) else $error("offset write lost");
    cover property ($fell(cal_busy_o));
    cover property (filt_valid_i && gain_correction_word_o == 24'h80_0000 && filt_data_i[22]);
    cover property (monitor_sel_i == 2'h3);
    cover property (cal_busy_o ##1 asleep_o);
endmodule
bind acc_control acc_control_chk #(.POR_CLKS(POR_CLKS)) acc_control_chk_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .filt_valid_i(filt_valid_i),
    .filt_data_i(filt_data_i), .system_gain_cal_cmd_i(system_gain_cal_cmd_i),
    .internal_offset_cal_cmd_i(internal_offset_cal_cmd_i), .ofs_wr_i(ofs_wr_i),
    .ofs_wdata_i(ofs_wdata_i), .amplifier_gain_setting_i(amplifier_gain_setting_i),
    .monitor_sel_i(monitor_sel_i), .offset_correction_word_o(offset_correction_word_o),
    .gain_correction_word_o(gain_correction_word_o), .result_o(result_o),
    .conversion_done_flag_o(conversion_done_flag_o), .inputs_disconnect_o(inputs_disconnect_o),
    .internal_short_o(internal_short_o), .eff_gain_o(eff_gain_o), .por_busy_o(por_busy_o),
    .cal_busy_o(cal_busy_o), .asleep_o(asleep_o), .sleep_cmd_i(sleep_cmd_i),
    .system_offset_cal_cmd_i(system_offset_cal_cmd_i));

// ==== testbench/acc_filt_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// modulator and decimation filter stand-in
module acc_filt_model (
    input wire clk_i,
    output logic mod_clk_o,
    output logic filt_valid_o,
    output logic [23:0] filt_data_o
);
    // modulator clock runs free, 64 ns, phase unrelated to clk_i
    initial begin
        mod_clk_o = 1'b0;
        #3.3;
        forever #32 mod_clk_o = ~mod_clk_o;
    end
    initial begin
        filt_valid_o = 1'b0;
        filt_data_o = 24'h5A_5A5A;
    end
    // one-cycle word; data is scrambled afterwards so stale reads show
    task send(input logic [23:0] d);
        @(posedge clk_i);
        #1;
        filt_valid_o = 1'b1;
        filt_data_o = d;
        @(posedge clk_i);
        #1;
        filt_valid_o = 1'b0;
        filt_data_o = ~d;
    endtask
endmodule

// ==== testbench/acc_control_tb.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// self-checking bench for the control block
module acc_control_tb;
    logic clk_i, reset_n_i, start_pin_i, sleep_cmd_i, wakeup_cmd_i, ofs_wr_i, gain_wr_i;
    logic sg_c, so_c, io_c; // calibration command pulses
    logic [23:0] ofs_wdata_i, gain_wdata_i;
    logic [2:0] amplifier_gain_setting_i;
    logic [1:0] reference_control_bits_i, monitor_sel_i;
    wire mod_clk, fv, done_n, frst, disc, shrt, ref_on, por_b, cal_b, slp;
    wire [23:0] fd, ofs_w, gain_w, res;
    wire [2:0] effg;
    int bad_count, num_checks, cycles, n;
    acc_filt_model acc_filt_model_i (.clk_i(clk_i), .mod_clk_o(mod_clk), .filt_valid_o(fv),
        .filt_data_o(fd));
    acc_control #(.POR_CLKS(16), .FULL_SCALE(24'h20_0000)) acc_control_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .start_pin_i(start_pin_i), .mod_clk_i(mod_clk),
        .filt_valid_i(fv), .filt_data_i(fd), .sleep_cmd_i(sleep_cmd_i),
        .wakeup_cmd_i(wakeup_cmd_i), .system_gain_cal_cmd_i(sg_c), .system_offset_cal_cmd_i(so_c),
        .internal_offset_cal_cmd_i(io_c), .ofs_wr_i(ofs_wr_i), .ofs_wdata_i(ofs_wdata_i),
        .gain_wr_i(gain_wr_i), .gain_wdata_i(gain_wdata_i),
        .amplifier_gain_setting_i(amplifier_gain_setting_i),
        .reference_control_bits_i(reference_control_bits_i), .monitor_sel_i(monitor_sel_i),
        .offset_correction_word_o(ofs_w), .gain_correction_word_o(gain_w), .result_o(res),
        .conversion_done_flag_o(done_n), .filter_reset_o(frst), .inputs_disconnect_o(disc),
        .internal_short_o(shrt), .eff_gain_o(effg), .ref_on_o(ref_on), .por_busy_o(por_b),
        .cal_busy_o(cal_b), .asleep_o(slp));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // hang guard, well above the roughly 3900 cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            conclude();
        end
    end
    task tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t word got %h expected %h", $time, got, exp);
        end
    endtask
    task chkb(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask
    // reference model of the scaling: wide product, arithmetic shift, saturate
    function automatic logic [23:0] scale(input logic [23:0] d, o, g);
        longint v;
        v = ((longint'($signed(d)) - longint'($signed(o))) * longint'(g)) >>> 22;
        if (v > 64'sh7F_FFFF) return 24'h7F_FFFF;
        if (v < -64'sh80_0000) return 24'h80_0000;
        return v[23:0];
    endfunction
    task wr(input logic [23:0] o, g);
        {ofs_wr_i, gain_wr_i, ofs_wdata_i, gain_wdata_i} = {2'b11, o, g};
        tick(1);
        {ofs_wr_i, gain_wr_i} = 2'b00;
        chk(ofs_w, o);
        chk(gain_w, g);
    endtask
    task t_por;
        chkb(por_b, 1'b1);
        for (int i = 0; i < 100 && por_b; i++) tick(1);
        chk(ofs_w, 24'h00_0000);
        chk(gain_w, 24'h40_0000);
        start_pin_i = 1'b1;
        tick(5);
        for (int i = 0; i < 1000 && frst; i++) tick(1);
    endtask
    task t_scale;
        logic [71:0] tab [8]; // data, offset, gain
        tab = '{72'h123456_000000_400000, 72'h000000_000001_400000, 72'h000000_800000_400000,
            72'h200000_000000_200000, 72'h300000_000000_000000, 72'h000000_FFFFFF_400000,
            72'h500000_000000_800000, 72'hB00000_000000_800000};
        foreach (tab[i]) begin
            wr(tab[i][47:24], tab[i][23:0]);
            acc_filt_model_i.send(tab[i][71:48]);
            chk(res, scale(tab[i][71:48], tab[i][47:24], tab[i][23:0]));
        end
    endtask
    task t_mon;
        amplifier_gain_setting_i = 3'h2;
        tick(3);
        chk(gain_w, 24'h40_0000);
        monitor_sel_i = 2'h3;
        tick(1);
        chk(effg, 3'h0);
        chkb(disc, 1'b1);
        monitor_sel_i = 2'h0;
        tick(1);
        chk(effg, 3'h2);
        chkb(disc, 1'b0);
    endtask
    task t_cal(input int k);
        wr(24'h00_0000, 24'h40_0000);
        {sg_c, so_c, io_c} = 3'b100 >> k;
        tick(1);
        {sg_c, so_c, io_c, sleep_cmd_i} = {3'b000, k == 2};
        chkb(cal_b, 1'b1);
        if (k == 2) chkb(shrt, 1'b1);
        tick(1);
        sleep_cmd_i = 1'b0;
        tick(599);
        for (int i = 0; i < 16; i++) begin
            acc_filt_model_i.send(k == 0 ? 24'h10_0000 : 24'h00_0100 + i[23:0]);
            tick(5);
        end
        for (int i = 0; i < 100 && cal_b; i++) tick(1);
        chkb(done_n, 1'b0);
        if (k == 0) begin
            chk(gain_w, 24'h80_0000);
            acc_filt_model_i.send(24'h10_0000);
            chk(res, 24'h20_0000);
        end else chk(ofs_w, 24'h00_0107);
        if (k == 2) begin
            tick(2);
            chkb(slp, 1'b1);
            reference_control_bits_i = 2'h1;
            tick(2);
            chkb(ref_on, 1'b1);
            reference_control_bits_i = 2'h0;
            tick(2);
            chkb(ref_on, 1'b0);
            wakeup_cmd_i = 1'b1;
            tick(1);
            wakeup_cmd_i = 1'b0;
        end
    endtask
    task t_single;
        start_pin_i = 1'b0;
        for (int i = 0; i < 1000 && frst; i++) tick(1);
        acc_filt_model_i.send(24'h00_0001);
        tick(2);
        chkb(slp, 1'b1);
        start_pin_i = 1'b1;
        tick(4);
        start_pin_i = 1'b0;
        for (int i = 0; i < 20 && !frst; i++) tick(1);
        for (n = 0; n < 1000 && frst; n++) tick(1);
        chkb(n >= 395 && n <= 412, 1'b1);
        acc_filt_model_i.send(24'h00_1234);
        chkb(done_n, 1'b0);
        tick(2);
        chkb(slp, 1'b1);
        start_pin_i = 1'b1;
        for (int i = 0; i < 20 && !frst; i++) tick(1);
        for (int i = 0; i < 1000 && frst; i++) tick(1);
        repeat (2) acc_filt_model_i.send(24'h00_0042);
        tick(2);
        chkb(slp, 1'b0);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {reset_n_i, start_pin_i, sleep_cmd_i, wakeup_cmd_i, ofs_wr_i, gain_wr_i} = 6'h0;
        {sg_c, so_c, io_c, ofs_wdata_i, gain_wdata_i} = 51'h0;
        {amplifier_gain_setting_i, reference_control_bits_i, monitor_sel_i} = 7'h0;
        tick(20);
        reset_n_i = 1'b1;
        tick(1);
        t_por();
        t_scale();
        t_mon();
        for (int k = 0; k < 3; k++) t_cal(k);
        t_single();
        conclude();
    end
endmodule
